// File: core/bdc_defs.svh
// constants for the bridge driver serial configuration block
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH

`define BDC_WORD_W 19
`define BDC_SEL_BIT 0
`define BDC_SEL_TIMING 1'b1

// timing word fields
`define BDC_BLANK_LSB 1
`define BDC_BLANK_MSB 2
`define BDC_OFF_LSB 3
`define BDC_OFF_MSB 7
`define BDC_FD_LSB 8
`define BDC_FD_MSB 11
`define BDC_MCK_LSB 12
`define BDC_MCK_MSB 13
`define BDC_SR_LSB 14
`define BDC_SR_MSB 15
`define BDC_RSV_LSB 16
`define BDC_RSV_MSB 17
`define BDC_IDLE_BIT 18

// phase-current word fields
`define BDC_DAC1_LSB 1
`define BDC_DAC1_MSB 6
`define BDC_PH1_BIT 7
`define BDC_MODE1_BIT 8
`define BDC_DAC2_LSB 9
`define BDC_DAC2_MSB 14
`define BDC_PH2_BIT 15
`define BDC_MODE2_BIT 16
`define BDC_RANGE_LSB 17
`define BDC_RANGE_MSB 18

// blanking and dead periods in master clock periods
`define BDC_BLANK_C0 4'h4
`define BDC_BLANK_C1 4'h6
`define BDC_BLANK_C2 4'h8
`define BDC_BLANK_C3 4'hc
`define BDC_DEAD_C0 3'h2

// master clock source codes
`define BDC_MCK_INT 2'h0
`define BDC_MCK_DIV1 2'h1
`define BDC_MCK_DIV2 2'h2
`define BDC_MCK_DIV4 2'h3
`define BDC_EXT_DIV1 3'h1
`define BDC_EXT_DIV2 3'h2
`define BDC_EXT_DIV4 3'h4

// internal oscillator model from the core clock
`define BDC_CORE_HZ 40000000
`define BDC_INT_CLK_HZ 4000000
`define BDC_INT_DIV (`BDC_CORE_HZ / `BDC_INT_CLK_HZ)
`define BDC_DIV_W 4

// off and fast-decay periods: (1+n)*8-1
`define BDC_PERIOD_STEP_SH 3
`define BDC_PERIOD_W 8
`define BDC_PERIOD_MIN 8'h07

`endif

// File: core/bdc_mclk_gen.sv
// master clock tick generator: internal oscillator or divided external clock
`timescale 1ns/1ps
`include "bdc_defs.svh"

module bdc_mclk_gen (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] source_in,
	input wire logic oscillator_input_pin_in,
	output logic mck_tick_out
);

	logic ext_clk_prev_reg;
	logic [`BDC_DIV_W-1:0] int_cnt_reg;
	logic [2:0] ext_cnt_reg;
	logic [2:0] ext_div;
	logic ext_clk_rise;

	assign ext_clk_rise = oscillator_input_pin_in & ~ext_clk_prev_reg;

	always_comb begin
		case (source_in)
			`BDC_MCK_DIV2: ext_div = `BDC_EXT_DIV2;
			`BDC_MCK_DIV4: ext_div = `BDC_EXT_DIV4;
			default: ext_div = `BDC_EXT_DIV1;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_clk_prev_reg <= 1'b0;
		end else begin
			ext_clk_prev_reg <= oscillator_input_pin_in;
		end
	end

	// internal oscillator stand-in
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_cnt_reg <= '0;
		end else if (int_cnt_reg == `BDC_DIV_W'(`BDC_INT_DIV - 1)) begin
			int_cnt_reg <= '0;
		end else begin
			int_cnt_reg <= int_cnt_reg + 1'b1;
		end
	end

	// external clock edge divider
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_cnt_reg <= '0;
		end else if (source_in == `BDC_MCK_INT) begin
			ext_cnt_reg <= '0;
		end else if (ext_clk_rise) begin
			if (ext_cnt_reg >= ext_div - 3'h1) begin
				ext_cnt_reg <= '0;
			end else begin
				ext_cnt_reg <= ext_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mck_tick_out <= 1'b0;
		end else if (source_in == `BDC_MCK_INT) begin
			mck_tick_out <= (int_cnt_reg == `BDC_DIV_W'(`BDC_INT_DIV - 1));
		end else begin
			mck_tick_out <= ext_clk_rise && (ext_cnt_reg >= ext_div - 3'h1);
		end
	end

endmodule

// File: core/bdc_pkg.sv
// types for the bridge driver serial configuration block
package bdc_pkg;

	typedef enum logic [1:0] {
		BDC_SR_OFF,
		BDC_SR_ACTIVE,
		BDC_SR_PASSIVE
	} bdc_sr_mode_t;

	typedef struct packed {
		logic enable;
		logic phase;
		logic slow_decay;
		logic [5:0] dac;
	} bdc_bridge_t;

	typedef struct packed {
		logic [3:0] blank_periods;
		logic [2:0] dead_periods;
		logic [7:0] off_periods;
		logic [7:0] fast_decay_periods;
		logic full_fast_decay;
	} bdc_timing_t;

endpackage

// File: core/bdc_serial_cfg.sv
// serial configuration registers of a dual full-bridge gate driver
// Behaviour
// - timing word writes accepted only while config write enable pin is low.
// - bit D0 picks destination: 1 timing word, 0 phase-current word.
// - D2:D1 set blanking to 4, 6, 8 or 12 master clock periods.
// - dead interval is half the blanking: 2, 3, 4 or 6 periods.
// - off interval is (1+n)*8-1 periods from five-bit field D7:D3.
// - fast-decay interval is (1+n)*8-1 periods from field D11:D8.
// - fast-decay longer than off interval means fast decay for whole off period.
// - D13:D12 pick internal oscillator or external clock divided by 1, 2, 4.
// - D15:D14 sync rectification: 00/01 off, 10 active, 11 passive.
// - D18 zero means idle: regulator and all outputs off, undervoltage watch stays.
// - phase-current word fields: two DAC codes, phases, modes, range select.
// - shift on serial clock rising edge only while strobe is low.
// - strobe rising edge latches only the last 19 shifted bits.
// - a bridge with all-zero current code is disabled, all gates off.
`timescale 1ns/1ps
`include "bdc_defs.svh"

module bdc_serial_cfg (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic serial_clock_pin_in,
	input wire logic serial_input_pin_in,
	input wire logic latch_strobe_pin_in,
	input wire logic config_write_enable_pin_in,
	input wire logic oscillator_input_pin_in,
	output logic serial_chain_output_out,
	output logic mck_tick_out,
	output logic gate_supply_regulator_en_out,
	output logic idle_out,
	output bdc_pkg::bdc_sr_mode_t sync_rect_mode_out,
	output logic [1:0] mck_source_out,
	output logic [1:0] range_select_out,
	output bdc_pkg::bdc_timing_t timing_out,
	output bdc_pkg::bdc_bridge_t [1:0] bridge_out
);

	// (1+n)*8-1 periods
	function automatic logic [`BDC_PERIOD_W-1:0] interval_periods(input logic [4:0] n);
		logic [`BDC_PERIOD_W-1:0] base;
		base = (`BDC_PERIOD_W'(n) + 1'b1) << `BDC_PERIOD_STEP_SH;
		interval_periods = base - 1'b1;
	endfunction

	function automatic logic [3:0] blank_periods(input logic [1:0] code);
		logic [3:0] p;
		p = `BDC_BLANK_C0;
		case (code)
			2'h1: p = `BDC_BLANK_C1;
			2'h2: p = `BDC_BLANK_C2;
			2'h3: p = `BDC_BLANK_C3;
			default: p = `BDC_BLANK_C0;
		endcase
		blank_periods = p;
	endfunction

	logic [`BDC_WORD_W-1:0] shift_reg;
	logic [`BDC_WORD_W-1:0] timing_word_reg;
	logic [`BDC_WORD_W-1:0] phase_word_reg;
	logic sck_prev_reg;
	logic strobe_prev_reg;
	logic sck_rise;
	logic strobe_rise;
	logic mck_tick;
	logic [3:0] blank_next;
	logic [`BDC_PERIOD_W-1:0] off_next;
	logic [`BDC_PERIOD_W-1:0] fd_next;
	logic [1:0] sr_code;
	logic [5:0] dac_code [1:0];

	assign sck_rise = serial_clock_pin_in & ~sck_prev_reg;
	assign strobe_rise = latch_strobe_pin_in & ~strobe_prev_reg;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sck_prev_reg <= 1'b0;
			strobe_prev_reg <= 1'b1;
		end else begin
			sck_prev_reg <= serial_clock_pin_in;
			strobe_prev_reg <= latch_strobe_pin_in;
		end
	end

	// shift register, MSB first so D0 ends at bit 0
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_reg <= '0;
		end else if (sck_rise && !latch_strobe_pin_in) begin
			shift_reg <= {shift_reg[`BDC_WORD_W-2:0], serial_input_pin_in};
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			serial_chain_output_out <= 1'b0;
		end else begin
			serial_chain_output_out <= shift_reg[`BDC_WORD_W-1];
		end
	end

	// timing word latch, guarded by write enable pin
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			timing_word_reg <= '0;
		end else if (strobe_rise &&
			shift_reg[`BDC_SEL_BIT] == `BDC_SEL_TIMING) begin
			if (!config_write_enable_pin_in) begin
				timing_word_reg <= shift_reg;
			end
		end
	end

	// phase-current word latch, write enable pin ignored
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_word_reg <= '0;
		end else if (strobe_rise &&
			shift_reg[`BDC_SEL_BIT] != `BDC_SEL_TIMING) begin
			phase_word_reg <= shift_reg;
		end
	end

	// master clock source and divider
	bdc_mclk_gen u_mclk (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.source_in(timing_word_reg[`BDC_MCK_MSB:`BDC_MCK_LSB]),
		.oscillator_input_pin_in(oscillator_input_pin_in),
		.mck_tick_out(mck_tick)
	);

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mck_tick_out <= 1'b0;
			mck_source_out <= `BDC_MCK_INT;
		end else begin
			mck_tick_out <= mck_tick;
			mck_source_out <= timing_word_reg[`BDC_MCK_MSB:`BDC_MCK_LSB];
		end
	end

	// timing decode
	always_comb begin
		blank_next = blank_periods(timing_word_reg[`BDC_BLANK_MSB:`BDC_BLANK_LSB]);
		off_next = interval_periods(timing_word_reg[`BDC_OFF_MSB:`BDC_OFF_LSB]);
		fd_next = interval_periods({1'b0, timing_word_reg[`BDC_FD_MSB:`BDC_FD_LSB]});
		sr_code = timing_word_reg[`BDC_SR_MSB:`BDC_SR_LSB];
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// decode of the all-zero word
			timing_out.blank_periods <= `BDC_BLANK_C0;
			timing_out.dead_periods <= `BDC_DEAD_C0;
			timing_out.off_periods <= `BDC_PERIOD_MIN;
			timing_out.fast_decay_periods <= `BDC_PERIOD_MIN;
			timing_out.full_fast_decay <= 1'b0;
		end else begin
			timing_out.blank_periods <= blank_next;
			timing_out.dead_periods <= blank_next[3:1];
			timing_out.off_periods <= off_next;
			timing_out.fast_decay_periods <= fd_next;
			timing_out.full_fast_decay <= (fd_next > off_next);
		end
	end

	// synchronous rectification mode
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_rect_mode_out <= bdc_pkg::BDC_SR_OFF;
		end else begin
			case (sr_code)
				2'h2: sync_rect_mode_out <= bdc_pkg::BDC_SR_ACTIVE;
				2'h3: sync_rect_mode_out <= bdc_pkg::BDC_SR_PASSIVE;
				default: sync_rect_mode_out <= bdc_pkg::BDC_SR_OFF;
			endcase
		end
	end

	// idle mode: regulator off, outputs off
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idle_out <= 1'b1;
			gate_supply_regulator_en_out <= 1'b0;
		end else begin
			idle_out <= ~timing_word_reg[`BDC_IDLE_BIT];
			gate_supply_regulator_en_out <= timing_word_reg[`BDC_IDLE_BIT];
		end
	end

	// phase-current word fields
	assign dac_code[0] = phase_word_reg[`BDC_DAC1_MSB:`BDC_DAC1_LSB];
	assign dac_code[1] = phase_word_reg[`BDC_DAC2_MSB:`BDC_DAC2_LSB];

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			range_select_out <= '0;
		end else begin
			range_select_out <= phase_word_reg[`BDC_RANGE_MSB:`BDC_RANGE_LSB];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bridge
			logic ph;
			logic md;
			assign ph = (gi == 0) ? phase_word_reg[`BDC_PH1_BIT] : phase_word_reg[`BDC_PH2_BIT];
			assign md = (gi == 0) ? phase_word_reg[`BDC_MODE1_BIT] :
				phase_word_reg[`BDC_MODE2_BIT];
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					bridge_out[gi] <= '0;
				end else begin
					bridge_out[gi].dac <= dac_code[gi];
					bridge_out[gi].phase <= ph;
					bridge_out[gi].slow_decay <= md;
					// zero code or idle turns the bridge off
					bridge_out[gi].enable <= (|dac_code[gi]) &&
						timing_word_reg[`BDC_IDLE_BIT];
				end
			end
		end
	endgenerate

endmodule

// File: verification/bdc_host_model.sv
// host model shifting words into the serial port
`timescale 1ns/1ps
module bdc_host_model (
	input wire logic core_clk_in,
	output logic sck_out,
	output logic data_out,
	output logic strobe_out
);
	initial begin
		sck_out = 1'b0;
		data_out = 1'b1;
		strobe_out = 1'b1;
	end
	task automatic shift_bit(input logic b);
		@(negedge core_clk_in) data_out = b;
		@(negedge core_clk_in) sck_out = 1'b1;
		repeat (2) @(negedge core_clk_in);
		sck_out = 1'b0;
		data_out = ~b;
		@(negedge core_clk_in);
	endtask
	task automatic junk(input logic [3:0] j);
		@(negedge core_clk_in) strobe_out = 1'b0;
		for (int i = 3; i >= 0; i--) shift_bit(j[i]);
	endtask
	task automatic send(input logic [18:0] w);
		@(negedge core_clk_in) strobe_out = 1'b0;
		for (int i = 18; i >= 0; i--) shift_bit(w[i]);
		@(negedge core_clk_in) strobe_out = 1'b1;
		repeat (4) @(negedge core_clk_in);
	endtask
endmodule

// File: verification/bdc_serial_cfg_props.sv
// assertions on the serial configuration block ports
`timescale 1ns/1ps
module bdc_serial_cfg_props (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic latch_strobe_pin_in,
	input wire logic serial_chain_output_out,
	input wire logic gate_supply_regulator_en_out,
	input wire logic idle_out,
	input wire bdc_pkg::bdc_timing_t timing_out,
	input wire bdc_pkg::bdc_bridge_t [1:0] bridge_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// a latched word reaches the outputs two edges after the strobe rises
	sequence strobe_held;
		latch_strobe_pin_in [*4];
	endsequence
	idle_supply_a: assert property (idle_out == !gate_supply_regulator_en_out)
		else $error("idle and regulator disagree");
	idle_gates_a: assert property (idle_out |->
		!bridge_out[0].enable && !bridge_out[1].enable)
		else $error("bridge enabled while idle");
	blank_set_a: assert property (
		timing_out.blank_periods inside {4'h4, 4'h6, 4'h8, 4'hc})
		else $error("bad blanking count");
	dead_half_a: assert property (
		timing_out.dead_periods == timing_out.blank_periods[3:1])
		else $error("dead count not half blanking");
	off_step_a: assert property (timing_out.off_periods[2:0] == 3'h7)
		else $error("off count off step");
	fd_step_a: assert property (
		timing_out.fast_decay_periods[2:0] == 3'h7 && !timing_out.fast_decay_periods[7])
		else $error("fast decay count off step");
	full_fd_a: assert property (
		timing_out.full_fast_decay ==
		(timing_out.fast_decay_periods > timing_out.off_periods))
		else $error("full fast decay flag wrong");
	zero_dac_a: assert property (
		(bridge_out[0].enable |-> bridge_out[0].dac != 6'h0) and
		(bridge_out[1].enable |-> bridge_out[1].dac != 6'h0))
		else $error("zero code bridge enabled");
	hold_cfg_a: assert property (strobe_held |->
		$stable(timing_out) && $stable(bridge_out) && $stable(idle_out))
		else $error("outputs moved without strobe");
	hold_chain_a: assert property (strobe_held |->
		$stable(serial_chain_output_out))
		else $error("shifted while strobe high");
endmodule
bind bdc_serial_cfg bdc_serial_cfg_props props (
	.core_clk_in(core_clk_in),
	.rst_b_in(rst_b_in),
	.latch_strobe_pin_in(latch_strobe_pin_in),
	.serial_chain_output_out(serial_chain_output_out),
	.gate_supply_regulator_en_out(gate_supply_regulator_en_out),
	.idle_out(idle_out),
	.timing_out(timing_out),
	.bridge_out(bridge_out)
);

// File: verification/tb_bdc_serial_cfg.sv
// testbench for the serial configuration block
`timescale 1ns/1ps
module tb_bdc_serial_cfg;
	logic clk, rst_b, sck, sdata, strobe, we_b, ext_clk, chain, tick, reg_en, idle;
	bdc_pkg::bdc_sr_mode_t sr;
	logic [1:0] mck, rng;
	bdc_pkg::bdc_timing_t tm;
	bdc_pkg::bdc_bridge_t [1:0] br;
	int fail_count, tests_run;
	logic [31:0] c;
	int offs[4] = '{0, 31, 3, 10};
	int fds[4] = '{15, 0, 3, 1};
	int blk[4] = '{4, 6, 8, 12};
	int srs[4] = '{0, 0, 1, 2};
	int tk[4] = '{32, 40, 20, 10};
	bdc_host_model host (.core_clk_in(clk), .sck_out(sck), .data_out(sdata), .strobe_out(strobe));
	bdc_serial_cfg dut (.core_clk_in(clk), .rst_b_in(rst_b), .serial_clock_pin_in(sck),
		.serial_input_pin_in(sdata), .latch_strobe_pin_in(strobe),
		.config_write_enable_pin_in(we_b), .oscillator_input_pin_in(ext_clk),
		.serial_chain_output_out(chain), .mck_tick_out(tick),
		.gate_supply_regulator_en_out(reg_en), .idle_out(idle), .sync_rect_mode_out(sr),
		.mck_source_out(mck), .range_select_out(rng), .timing_out(tm), .bridge_out(br));
	function automatic logic [18:0] tw(input int b, o, f, m, s, run);
		return {run[0], 2'h0, s[1:0], m[1:0], f[3:0], o[4:0], b[1:0], 1'b1};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		ext_clk = 1'b0;
		forever begin
			repeat (4) @(negedge clk);
			ext_clk = ~ext_clk;
		end
	end
	initial begin
		#2000000;
		$display("MISMATCH %0t run did not finish in time", $time);
		fail_count++;
		close_out();
	end
	initial begin
		rst_b = 1'b0;
		we_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk(idle, 1'b1, "reset idle");
		chk(tm, {4'h4, 3'h2, 8'h07, 8'h07, 1'b0}, "reset timing");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			host.send(tw(i, offs[i], fds[i], i, i, 1));
			chk(tm.blank_periods, blk[i], "blank");
			chk(tm.dead_periods, blk[i] / 2, "dead");
			chk(tm.off_periods, (offs[i] + 1) * 8 - 1, "off");
			chk(tm.fast_decay_periods, (fds[i] + 1) * 8 - 1, "fd");
			chk(tm.full_fast_decay, fds[i] > offs[i], "full fd");
			chk(mck, i, "mck src");
			chk(sr, srs[i], "sr mode");
			chk(chain, 1'b1, "chain");
			repeat (64) @(negedge clk);
			c = '0;
			repeat (320) begin
				@(negedge clk);
				c += tick;
			end
			chk(c, tk[i], "ticks");
		end
		$display("test timing word done");
		we_b = 1'b1;
		host.send(tw(1, 5, 5, 0, 0, 1));
		chk(tm.blank_periods, 4'hc, "locked blank");
		chk(sr, bdc_pkg::BDC_SR_PASSIVE, "locked sr");
		// regulator settles for 1 ms before any bridge is enabled
		repeat (40000) @(negedge clk);
		host.send({2'h2, 1'b1, 1'b0, 6'h00, 1'b0, 1'b1, 6'h3f, 1'b0});
		chk(br[0], {1'b1, 1'b1, 1'b0, 6'h3f}, "bridge1");
		chk(br[1], {1'b0, 1'b0, 1'b1, 6'h00}, "bridge2");
		chk(rng, 2'h2, "range");
		host.shift_bit(1'b0);
		chk(chain, 1'b1, "no shift while strobe high");
		$display("test lock and phase word done");
		we_b = 1'b0;
		host.junk(4'hf);
		host.send(tw(0, 0, 0, 0, 0, 0));
		chk(tm.blank_periods, 4'h4, "junk blank");
		chk(chain, 1'b0, "chain idle");
		chk({idle, reg_en, br[0].enable}, 3'h4, "idle");
		$display("test idle done");
		close_out();
	end
endmodule
